// ---- logic/limit_alarm_restart_logic.sv ----
// Limit alarms, threshold access, restart handling and serial write depth
`timescale 1ns/1ps
`default_nettype none
`include "limit_alarm_regs.svh"

module limit_alarm_restart_logic
  import limit_alarm_pkg::*;
#(
  parameter int VW   = 16,
  parameter int NVAR = 38
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic [NVAR*VW-1:0] var_bus_i,
  input  wire logic [VW-1:0]     ctrl1_span_start_i,
  input  wire logic [VW-1:0]     ctrl1_span_end_i,
  input  wire logic [VW-1:0]     ctrl2_span_start_i,
  input  wire logic [VW-1:0]     ctrl2_span_end_i,
  input  wire logic              shift_key_i,
  input  wire logic              restart_event_i,
  input  wire logic              cur_manual_i,
  input  wire logic              cur_internal_i,
  input  wire logic              cur_slave_internal_i,
  input  wire logic [VW-1:0]     cur_manip_i,
  input  wire logic              host_req_i,
  input  wire logic [1:0]        host_kind_i,
  output logic [3:0]             alarm_o,
  output logic [2:0]             display_item_o,
  output logic                   display_flash_o,
  output logic                   restart_valid_o,
  output logic                   restart_manual_o,
  output logic                   restart_internal_o,
  output logic                   restart_slave_internal_o,
  output logic [VW-1:0]          restart_manip_o,
  output logic                   host_grant_o,
  output logic                   host_deny_o,
  output logic                   serial_ext_source_o
);

  // Register file state
  logic [31:0]   source_r, source_nxt;
  logic [31:0]   mode_r, mode_nxt;
  logic [31:0]   hyst_r, hyst_nxt;
  logic [VW-1:0] thr_r [4];
  logic [VW-1:0] thr_nxt [4];
  logic [VW-1:0] safety_r, safety_nxt;
  logic          refuse_r, refuse_nxt;
  logic [31:0]   rdata_r, rdata_nxt;
  logic          ack_r, ack_nxt;

  // Block state
  logic [3:0]     alarm_r, alarm_nxt;
  display_item_t  item_r, item_nxt;
  logic           flash_r, flash_nxt;
  logic [2:0]     key_sync_r;
  logic           shift_press;
  restart_state_t rs_r, rs_nxt;
  logic           last_manual_r, last_internal_r, last_slave_r;
  logic [VW-1:0]  last_manip_r;
  logic           rv_r, rv_nxt, rm_r, rm_nxt, ri_r, ri_nxt, rsl_r, rsl_nxt;
  logic [VW-1:0]  ry_r, ry_nxt;
  logic           grant_r, grant_nxt, deny_r, deny_nxt, ext_r, ext_nxt;

  // Decoded configuration
  logic [1:0] serial_depth;
  logic       struct_mode, thr_adjust, thr_show;
  logic       wb_write;
  logic       thr_write_ok;

  assign serial_depth = mode_r[`LA_MODE_DEPTH_POS +: 2];
  assign struct_mode  = mode_r[`LA_MODE_STRUCT_POS];
  assign thr_adjust   = mode_r[`LA_MODE_ADJ_POS];
  assign thr_show     = mode_r[`LA_MODE_SHOW_POS];
  assign wb_write     = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_r;
  assign thr_write_ok = struct_mode | thr_adjust;

  // Byte-lane merge for 32-bit registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Hysteresis field limited to 1..200 tenths of a percent
  function automatic logic [7:0] hyst_lim(input logic [7:0] h);
    if (h < `LA_HYST_MIN) begin
      return `LA_HYST_MIN;
    end
    if (h > `LA_HYST_MAX) begin
      return `LA_HYST_MAX;
    end
    return h;
  endfunction

  // Wishbone slave: one wait state, registered ack and read data
  always_comb begin
    logic [31:0] wm;
    wm         = 32'h0000_0000;
    source_nxt = source_r;
    mode_nxt   = mode_r;
    hyst_nxt   = hyst_r;
    safety_nxt = safety_r;
    refuse_nxt = refuse_r;
    thr_nxt    = thr_r;
    rdata_nxt  = rdata_r;
    ack_nxt    = wb_cyc_i & wb_stb_i & ~ack_r;
    if (wb_write) begin
      case (wb_adr_i)
        `LA_OFS_SOURCE: source_nxt = merge(source_r, wb_dat_i, wb_sel_i);
        `LA_OFS_MODE:   mode_nxt   = merge(mode_r, wb_dat_i, wb_sel_i);
        `LA_OFS_SAFETY: begin
          wm         = merge({{(32-VW){1'b0}}, safety_r}, wb_dat_i, wb_sel_i);
          safety_nxt = wm[VW-1:0];
        end
        `LA_OFS_HYST: begin
          hyst_nxt = merge(hyst_r, wb_dat_i, wb_sel_i);
          for (int k = 0; k < 4; k++) begin
            hyst_nxt[k*8 +: 8] = hyst_lim(hyst_nxt[k*8 +: 8]);
          end
          if (!struct_mode) begin
            hyst_nxt   = hyst_r;
            refuse_nxt = 1'b1;
          end
        end
        `LA_OFS_THR1, `LA_OFS_THR2, `LA_OFS_THR3, `LA_OFS_THR4: begin
          if (thr_write_ok) begin
            wm = merge({{(32-VW){1'b0}}, thr_r[wb_adr_i[3:2] - 2'd2]}, wb_dat_i, wb_sel_i);
            thr_nxt[wb_adr_i[3:2] - 2'd2] = wm[VW-1:0];
          end else begin
            refuse_nxt = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~ack_r) begin
      case (wb_adr_i)
        `LA_OFS_SOURCE: rdata_nxt = source_r;
        `LA_OFS_MODE:   rdata_nxt = mode_r;
        `LA_OFS_THR1:   rdata_nxt = {{(32-VW){thr_r[0][VW-1]}}, thr_r[0]};
        `LA_OFS_THR2:   rdata_nxt = {{(32-VW){thr_r[1][VW-1]}}, thr_r[1]};
        `LA_OFS_THR3:   rdata_nxt = {{(32-VW){thr_r[2][VW-1]}}, thr_r[2]};
        `LA_OFS_THR4:   rdata_nxt = {{(32-VW){thr_r[3][VW-1]}}, thr_r[3]};
        `LA_OFS_HYST:   rdata_nxt = hyst_r;
        `LA_OFS_SAFETY: rdata_nxt = {{(32-VW){1'b0}}, safety_r};
        `LA_OFS_STATUS: begin
          rdata_nxt = 32'h0000_0000;
          rdata_nxt[`LA_STAT_ALARM_POS +: 4] = alarm_r;
          rdata_nxt[`LA_STAT_FLASH_POS]      = flash_r;
          rdata_nxt[`LA_STAT_ITEM_POS +: 3]  = item_r;
          rdata_nxt[`LA_STAT_REFUSE_POS]     = refuse_r;
        end
        default: rdata_nxt = 32'h0000_0000;
      endcase
      // Reading status clears the refusal flag
      if (wb_adr_i == `LA_OFS_STATUS) begin
        refuse_nxt = 1'b0;
      end
    end
    // A refusal in the same access wins over the clear
    if (wb_write && refuse_nxt && !refuse_r) begin
      refuse_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      source_r <= `LA_SOURCE_RST;
      mode_r   <= `LA_MODE_RST;
      hyst_r   <= `LA_HYST_RST;
      safety_r <= '0;
      refuse_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
      ack_r    <= 1'b0;
      for (int k = 0; k < 4; k++) begin
        thr_r[k] <= `LA_THR_RST;
      end
    end else begin
      source_r <= source_nxt;
      mode_r   <= mode_nxt;
      hyst_r   <= hyst_nxt;
      safety_r <= safety_nxt;
      refuse_r <= refuse_nxt;
      rdata_r  <= rdata_nxt;
      ack_r    <= ack_nxt;
      thr_r    <= thr_nxt;
    end
  end

  // Alarm evaluation; thresholds are clamped at use so a span change stays safe
  always_comb begin
    int                 code;
    int                 pair;
    logic               second;
    logic               combined;
    logic               is_max;
    logic [1:0]         fn;
    logic signed [31:0] v, t, st, en, span, lo, hi, h;
    code = 0; pair = 0; second = 1'b0; combined = 1'b0; is_max = 1'b0; fn = 2'd0;
    v = 0; t = 0; st = 0; en = 0; span = 0; lo = 0; hi = 0; h = 0;
    alarm_nxt = alarm_r;
    for (int i = 0; i < 4; i++) begin
      pair   = i / 2;
      second = (i % 2) == 1;
      combined = source_r[(2*pair+1)*8 +: `LA_SRC_W] == `LA_SRC_PAIRED;
      code = (second && combined) ? int'($signed(source_r[(2*pair)*8 +: `LA_SRC_W]))
                                  : int'($signed(source_r[i*8 +: `LA_SRC_W]));
      if (code < 0 || code > `LA_SRC_LAST) begin
        code = 0;
      end
      v = 32'(signed'(var_bus_i[code*VW +: VW]));
      if (code <= `LA_SRC_CTRL1_LAST) begin
        st = 32'(signed'(ctrl1_span_start_i));
        en = 32'(signed'(ctrl1_span_end_i));
      end else if (code <= `LA_SRC_CTRL2_LAST) begin
        st = 32'(signed'(ctrl2_span_start_i));
        en = 32'(signed'(ctrl2_span_end_i));
      end else begin
        st = 0;
        en = `LA_PCT_SPAN;
      end
      span = en - st;
      // threshold within 110 % of span
      lo = st - (span * `LA_PCT_LIMIT) / `LA_PCT_SPAN;
      hi = st + (span * `LA_PCT_LIMIT) / `LA_PCT_SPAN;
      // Falling span: the bounds come out swapped
      if (lo > hi) begin
        t  = lo;
        lo = hi;
        hi = t;
      end
      if (lo < `LA_DISP_MIN) lo = `LA_DISP_MIN;
      if (hi > `LA_DISP_MAX) hi = `LA_DISP_MAX;
      t = 32'(signed'(thr_r[i]));
      if (t < lo) t = lo;
      if (t > hi) t = hi;
      if (second && !combined) begin
        h = 32'(hyst_r[(pair == 0 ? `LA_HYST_A2_POS : `LA_HYST_A4_POS) +: 8]);
      end else begin
        h = 32'(hyst_r[(pair == 0 ? `LA_HYST_P12_POS : `LA_HYST_P34_POS) +: 8]);
      end
      h = (h * (span < 0 ? -span : span)) / `LA_PCT_SPAN;
      fn = pair == 0 ? mode_r[`LA_MODE_FN12_POS +: 2] : mode_r[`LA_MODE_FN34_POS +: 2];
      is_max = second ? fn[1] : ~fn[0];
      if (en < st) begin
        is_max = ~is_max;
      end
      if (is_max) begin
        if (v > t) alarm_nxt[i] = 1'b1;
        else if (v < t - h) alarm_nxt[i] = 1'b0;
      end else begin
        if (v < t) alarm_nxt[i] = 1'b1;
        else if (v > t + h) alarm_nxt[i] = 1'b0;
      end
    end
  end

  // Front panel key is asynchronous: two flops, then a third for the edge
  assign shift_press = key_sync_r[1] & ~key_sync_r[2];

  // Display item stepping and recovery flash
  always_comb begin
    item_nxt  = item_r;
    flash_nxt = flash_r;
    if (shift_press) begin
      case (item_r)
        ITEM_CTRL1: item_nxt = ITEM_CTRL2;
        ITEM_CTRL2: item_nxt = thr_show ? ITEM_A1 : ITEM_CTRL1;
        ITEM_A1:    item_nxt = ITEM_A2;
        ITEM_A2:    item_nxt = ITEM_A3;
        ITEM_A3:    item_nxt = ITEM_A4;
        default:    item_nxt = ITEM_CTRL1;
      endcase
    end
    // flash acknowledged by key or host
    if (shift_press || (host_req_i && host_kind_i == HOST_ALARM_REQ)) begin
      flash_nxt = 1'b0;
    end
    if (restart_event_i && mode_r[`LA_MODE_FLASH_POS]) begin
      flash_nxt = 1'b1;
    end
  end

  // Restart sequencing: snapshot runs until the restart event freezes it
  always_comb begin
    rs_nxt  = rs_r;
    rv_nxt  = 1'b0;
    rm_nxt  = rm_r;
    ri_nxt  = ri_r;
    rsl_nxt = rsl_r;
    ry_nxt  = ry_r;
    case (rs_r)
      RS_RUN: begin
        if (restart_event_i) begin
          rs_nxt = RS_APPLY;
        end
      end
      RS_APPLY: begin
        rs_nxt = RS_RUN;
        rv_nxt = 1'b1;
        if (!mode_r[`LA_MODE_RESTART_POS]) begin
          rm_nxt  = last_manual_r;
          ri_nxt  = last_internal_r;
          rsl_nxt = last_slave_r;
          ry_nxt  = last_manip_r;
        end else begin
          rm_nxt  = 1'b1;
          ri_nxt  = 1'b1;
          rsl_nxt = 1'b1;
          ry_nxt  = mode_r[`LA_MODE_STEP_POS] ? last_manip_r : safety_r;
          if (mode_r[`LA_MODE_ONLYEXT_POS]) begin
            ri_nxt  = 1'b0;
            rsl_nxt = 1'b0;
          end
          if (mode_r[`LA_MODE_ONLYAUTO_POS]) begin
            rm_nxt = 1'b0;
          end
        end
      end
      default: rs_nxt = RS_RUN;
    endcase
  end

  // Serial host access by depth; reads never depend on it
  always_comb begin
    grant_nxt = 1'b0;
    deny_nxt  = 1'b0;
    ext_nxt   = serial_depth >= 2'd2;
    if (host_req_i) begin
      case (host_kind_i)
        HOST_READ, HOST_ALARM_REQ: grant_nxt = 1'b1;
        // depth 0 refuses, depth 1 parameters
        HOST_PARAM: grant_nxt = serial_depth != 2'd0;
        HOST_PROCESS: grant_nxt = serial_depth >= 2'd2;
        default: grant_nxt = 1'b0;
      endcase
      deny_nxt = ~grant_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      alarm_r         <= 4'h0;
      item_r          <= ITEM_CTRL1;
      flash_r         <= 1'b0;
      key_sync_r      <= 3'h0;
      rs_r            <= RS_RUN;
      last_manual_r   <= 1'b1;
      last_internal_r <= 1'b1;
      last_slave_r    <= 1'b1;
      last_manip_r    <= '0;
      rv_r            <= 1'b0;
      rm_r            <= 1'b1;
      ri_r            <= 1'b1;
      rsl_r           <= 1'b1;
      ry_r            <= '0;
      grant_r         <= 1'b0;
      deny_r          <= 1'b0;
      ext_r           <= 1'b0;
    end else begin
      alarm_r    <= alarm_nxt;
      item_r     <= item_nxt;
      flash_r    <= flash_nxt;
      key_sync_r <= {key_sync_r[1:0], shift_key_i};
      rs_r       <= rs_nxt;
      // Snapshot frozen once restart is signalled
      if (rs_r == RS_RUN && !restart_event_i) begin
        last_manual_r   <= cur_manual_i;
        last_internal_r <= cur_internal_i;
        last_slave_r    <= cur_slave_internal_i;
        last_manip_r    <= cur_manip_i;
      end
      rv_r    <= rv_nxt;
      rm_r    <= rm_nxt;
      ri_r    <= ri_nxt;
      rsl_r   <= rsl_nxt;
      ry_r    <= ry_nxt;
      grant_r <= grant_nxt;
      deny_r  <= deny_nxt;
      ext_r   <= ext_nxt;
    end
  end

  // Outputs straight from flops
  assign wb_dat_o                 = rdata_r;
  assign wb_ack_o                 = ack_r;
  assign alarm_o                  = alarm_r;
  assign display_item_o           = item_r;
  assign display_flash_o          = flash_r;
  assign restart_valid_o          = rv_r;
  assign restart_manual_o         = rm_r;
  assign restart_internal_o       = ri_r;
  assign restart_slave_internal_o = rsl_r;
  assign restart_manip_o          = ry_r;
  assign host_grant_o             = grant_r;
  assign host_deny_o              = deny_r;
  assign serial_ext_source_o      = ext_r;

endmodule
`default_nettype wire

// ---- logic/limit_alarm_regs.svh ----
// Register offsets, field positions, reset values and limits of the limit alarm block
`ifndef LIMIT_ALARM_REGS_SVH
`define LIMIT_ALARM_REGS_SVH

// Register byte offsets
`define LA_OFS_SOURCE      8'h00
`define LA_OFS_MODE        8'h04
`define LA_OFS_THR1        8'h08
`define LA_OFS_THR2        8'h0C
`define LA_OFS_THR3        8'h10
`define LA_OFS_THR4        8'h14
`define LA_OFS_HYST        8'h18
`define LA_OFS_STATUS      8'h1C
`define LA_OFS_SAFETY      8'h20

// Source register: one 6-bit signed code per alarm
`define LA_SRC_A1_POS      0
`define LA_SRC_A2_POS      8
`define LA_SRC_A3_POS      16
`define LA_SRC_A4_POS      24
`define LA_SRC_W           6
`define LA_SRC_PAIRED      6'h3F
`define LA_SRC_LAST        37
`define LA_SRC_CTRL1_LAST  4
`define LA_SRC_CTRL2_LAST  7
`define LA_SOURCE_RST      32'h3F00_3F00

// Mode register fields
`define LA_MODE_FN12_POS   0
`define LA_MODE_FN34_POS   2
`define LA_MODE_ADJ_POS    4
`define LA_MODE_SHOW_POS   5
`define LA_MODE_RESTART_POS 6
`define LA_MODE_FLASH_POS  7
`define LA_MODE_DEPTH_POS  8
`define LA_MODE_STRUCT_POS 10
`define LA_MODE_STEP_POS   11
`define LA_MODE_ONLYEXT_POS 12
`define LA_MODE_ONLYAUTO_POS 13
`define LA_MODE_RST        32'h0000_0020

// Hysteresis register: four 8-bit fields in 0.1 % units
`define LA_HYST_P12_POS    0
`define LA_HYST_P34_POS    8
`define LA_HYST_A2_POS     16
`define LA_HYST_A4_POS     24
`define LA_HYST_MIN        8'h01
`define LA_HYST_MAX        8'hC8
`define LA_HYST_RST        32'h0A0A_0A0A

// Threshold limits, 0.1 % of span and display counts
`define LA_PCT_SPAN        1000
`define LA_PCT_LIMIT       1100
`define LA_DISP_MIN        (-1999)
`define LA_DISP_MAX        19999
`define LA_THR_RST         16'h0000

// Status register fields
`define LA_STAT_ALARM_POS  0
`define LA_STAT_FLASH_POS  4
`define LA_STAT_ITEM_POS   5
`define LA_STAT_REFUSE_POS 8

`endif

// ---- logic/limit_alarm_pkg.sv ----
// Types shared by the limit alarm block
package limit_alarm_pkg;
  typedef enum logic [2:0] {
    ITEM_CTRL1, ITEM_CTRL2, ITEM_A1, ITEM_A2, ITEM_A3, ITEM_A4
  } display_item_t;
  typedef enum logic [1:0] {
    HOST_READ, HOST_PARAM, HOST_PROCESS, HOST_ALARM_REQ
  } host_kind_t;
  typedef enum logic {RS_RUN, RS_APPLY} restart_state_t;
endpackage

// ---- bench/limit_alarm_restart_logic_sva.sv ----
// Port-level assertion checker for the limit alarm block
`timescale 1ns/1ps
`default_nettype none
module limit_alarm_restart_logic_sva
  import limit_alarm_pkg::*;
#(
  parameter int VW   = 16,
  parameter int NVAR = 38
) (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               wb_cyc_i,
  input wire logic               wb_stb_i,
  input wire logic               wb_we_i,
  input wire logic               wb_ack_o,
  input wire logic [NVAR*VW-1:0] var_bus_i,
  input wire logic               host_req_i,
  input wire logic [1:0]         host_kind_i,
  input wire logic               host_grant_o,
  input wire logic               host_deny_o,
  input wire logic               restart_event_i,
  input wire logic               restart_valid_o,
  input wire logic [VW-1:0]      restart_manip_o,
  input wire logic [3:0]         alarm_o,
  input wire logic [2:0]         display_item_o,
  input wire logic               display_flash_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Bus write as seen at the slave; alarm outputs may follow it two edges on
  wire logic wr_w;
  assign wr_w = wb_cyc_i && wb_stb_i && wb_we_i;

  property p_wb_ack;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_wb_ack: assert property (p_wb_ack)
    else $error("bus request not answered by a single ack");
  property p_host_read;
    host_req_i && (host_kind_i == HOST_READ || host_kind_i == HOST_ALARM_REQ) |=> host_grant_o;
  endproperty
  a_host_read: assert property (p_host_read)
    else $error("read or alarm request not granted");
  property p_host_one;
    host_req_i |=> host_grant_o != host_deny_o;
  endproperty
  a_host_one: assert property (p_host_one)
    else $error("host request needs exactly one of grant and deny");
  property p_host_cause;
    host_grant_o || host_deny_o |-> $past(host_req_i);
  endproperty
  a_host_cause: assert property (p_host_cause)
    else $error("host answer without request");
  property p_restart;
    restart_event_i |-> ##2 restart_valid_o;
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart values not presented two cycles after event");
  property p_restart_hold;
    $changed(restart_manip_o) |-> restart_valid_o;
  endproperty
  a_restart_hold: assert property (p_restart_hold)
    else $error("restart value moved outside a restart");
  property p_item_step;
    $changed(display_item_o) |-> display_item_o == ($past(display_item_o) == 3'h5 ? 3'h0 :
      $past(display_item_o) + 3'h1) || ($past(display_item_o) == 3'h1 && display_item_o == 3'h0);
  endproperty
  a_item_step: assert property (p_item_step)
    else $error("display item left its cycle");
  property p_flash_set;
    $rose(display_flash_o) |-> $past(restart_event_i);
  endproperty
  a_flash_set: assert property (p_flash_set)
    else $error("flash started without restart");
  property p_flash_clear;
    display_flash_o && host_req_i && host_kind_i == HOST_ALARM_REQ && !restart_event_i
      |=> !display_flash_o;
  endproperty
  a_flash_clear: assert property (p_flash_clear)
    else $error("alarm request did not end flashing");
  property p_alarm_cause;
    $changed(alarm_o) |-> $past(var_bus_i) != $past(var_bus_i, 2) || $past(wr_w) || $past(wr_w, 2);
  endproperty
  a_alarm_cause: assert property (p_alarm_cause)
    else $error("alarm moved without variable or setting change");
endmodule

bind limit_alarm_restart_logic limit_alarm_restart_logic_sva #(.VW(VW), .NVAR(NVAR)) sva_i (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .var_bus_i(var_bus_i), .host_req_i(host_req_i),
  .host_kind_i(host_kind_i), .host_grant_o(host_grant_o), .host_deny_o(host_deny_o),
  .restart_event_i(restart_event_i), .restart_valid_o(restart_valid_o),
  .restart_manip_o(restart_manip_o), .alarm_o(alarm_o), .display_item_o(display_item_o),
  .display_flash_o(display_flash_o));
`default_nettype wire

// ---- bench/panel_host_model.sv ----
// Front panel key and serial host stand-in
`timescale 1ns/1ps
`default_nettype none
module panel_host_model (
  input  wire logic       clk_i,
  output var  logic       shift_key_o,
  output var  logic [1:0] host_kind_o,
  output var  logic       host_req_o
);
  // Idle levels at time zero
  initial begin
    shift_key_o = 1'b0;
    host_req_o  = 1'b0;
    host_kind_o = 2'h0;
  end
  // press held long enough to cross the key synchroniser
  task automatic press();
    @(posedge clk_i);
    shift_key_o <= 1'b1;
    repeat (6) @(posedge clk_i);
    shift_key_o <= 1'b0;
    repeat (6) @(posedge clk_i);
  endtask
  // one-cycle request; kind is scrambled after it so nothing stale lingers
  task automatic request(input logic [1:0] kind);
    @(posedge clk_i);
    host_req_o  <= 1'b1;
    host_kind_o <= kind;
    @(posedge clk_i);
    host_req_o  <= 1'b0;
    host_kind_o <= ~kind;
  endtask
endmodule
`default_nettype wire

// ---- bench/test_limit_alarm_restart_logic.sv ----
// Self-checking bench for limit alarms, restart and serial depth
`timescale 1ns/1ps
`default_nettype none
`include "limit_alarm_regs.svh"
module test_limit_alarm_restart_logic;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, evt = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000, r, e;
  logic [18:0] cur = 19'h0_0000;
  logic [607:0] var_bus = '0;
  logic [15:0] span_lo = 16'h0000, span_hi = 16'h03E8;
  logic [31:0] rdat;
  logic        ack, flash, grant, deny, ext_src, rvalid, key, hreq;
  logic [3:0]  alarm;
  logic [2:0]  item;
  logic [1:0]  hkind;
  wire  [18:0] rres;
  int          miscompares = 0, compares = 0;
  logic [31:0] qd[$];
  logic [1:0]  qh[$];
  logic [18:0] qr[$];
  logic [31:0] rmode[5] = '{32'h0000_00A0, 32'h0000_00E0, 32'h0000_08E0, 32'h0000_10E0,
                            32'h0000_20E0};

  always #2.5 clk_i = ~clk_i;

  limit_alarm_restart_logic limit_alarm_restart_logic_i (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .var_bus_i(var_bus), .ctrl1_span_start_i(span_lo), .ctrl1_span_end_i(span_hi),
    .ctrl2_span_start_i(span_lo), .ctrl2_span_end_i(span_hi), .shift_key_i(key),
    .restart_event_i(evt), .cur_manual_i(cur[18]), .cur_internal_i(cur[17]),
    .cur_slave_internal_i(cur[16]), .cur_manip_i(cur[15:0]), .host_req_i(hreq),
    .host_kind_i(hkind), .alarm_o(alarm), .display_item_o(item), .display_flash_o(flash),
    .restart_valid_o(rvalid), .restart_manual_o(rres[18]), .restart_internal_o(rres[17]),
    .restart_slave_internal_o(rres[16]), .restart_manip_o(rres[15:0]),
    .host_grant_o(grant), .host_deny_o(deny), .serial_ext_source_o(ext_src));

  panel_host_model panel_host_model_i (
    .clk_i(clk_i), .shift_key_o(key), .host_kind_o(hkind), .host_req_o(hreq));

  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    compares++;
    if (g !== x) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Classic single cycle; waits for ack, only the watchdog bounds it
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    qd.push_back(x);
    wb(1'b0, a, 32'h0000_0000);
  endtask

  // Drives the watched variable, stirs unused codes, then checks the alarms
  task automatic setv(input logic [15:0] v, input logic [3:0] x);
    @(posedge clk_i);
    var_bus[160 +: 16] <= v;
    for (int i = 11; i < 38; i++) var_bus[i*16 +: 16] <= 16'($urandom);
    repeat (4) @(posedge clk_i);
    chk("alarm_o", x, alarm);
  endtask

  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Result watcher: every answer takes the oldest note of its kind
  always @(negedge clk_i) begin
    if (ack === 1'b1 && we === 1'b0) chk("wb_dat_o", qd.size() ? qd.pop_front() : ~rdat, rdat);
    if ((grant | deny) === 1'b1) chk("host", qh.size() ? qh.pop_front() : 2'h3, {grant, deny});
    if (rvalid === 1'b1) chk("restart", qr.size() ? qr.pop_front() : ~rres, rres);
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge clk_i);
    miscompares++;
    final_report();
  end

  initial begin
    void'($urandom(72));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(`LA_OFS_SOURCE, `LA_SOURCE_RST);
    rd(`LA_OFS_MODE, `LA_MODE_RST);
    rd(`LA_OFS_HYST, `LA_HYST_RST);
    rd(8'h40, 32'h0000_0000);
    wb(1'b1, `LA_OFS_MODE, 32'h0000_0420);
    wb(1'b1, `LA_OFS_HYST, 32'hC805_FF00);
    wb(1'b1, `LA_OFS_THR3, 32'h0000_0123);
    rd(`LA_OFS_HYST, 32'hC805_C801);
    rd(`LA_OFS_THR3, 32'h0000_0123);
    // Operation level without adjust refuses thresholds and hysteresis
    wb(1'b1, `LA_OFS_MODE, 32'h0000_0020);
    wb(1'b1, `LA_OFS_THR1, 32'h0000_0123);
    wb(1'b1, `LA_OFS_HYST, 32'h0A0A_0A0A);
    rd(`LA_OFS_THR1, 32'h0000_0000);
    rd(`LA_OFS_HYST, 32'hC805_C801);
    rd(`LA_OFS_STATUS, 32'h0000_0100);
    rd(`LA_OFS_STATUS, 32'h0000_0000);
    wb(1'b1, `LA_OFS_MODE, 32'h0000_0030);
    wb(1'b1, `LA_OFS_THR1, 32'h0000_01F4);
    wb(1'b1, `LA_OFS_THR2, 32'h0000_00C8);
    rd(`LA_OFS_THR1, 32'h0000_01F4);
    wb(1'b1, `LA_OFS_MODE, 32'h0000_0430);
    wb(1'b1, `LA_OFS_HYST, 32'hC8C8_0A0A);
    wb(1'b1, `LA_OFS_SOURCE, 32'h3F00_3F0A);
    // Both alarms watch code 10; every pair function at a value above both
    for (int f = 0; f < 4; f++) begin
      wb(1'b1, `LA_OFS_MODE, 32'h0000_0030 | f);
      setv(16'h0258, {2'b00, f[1], ~f[0]});
    end
    wb(1'b1, `LA_OFS_MODE, 32'h0000_0030);
    setv(16'h0258, 4'h1);
    setv(16'h01EF, 4'h1);
    setv(16'h01E9, 4'h0);
    setv(16'h0096, 4'h2);
    setv(16'h00CD, 4'h2);
    setv(16'h00D3, 4'h0);
    wb(1'b1, `LA_OFS_THR1, 32'h0000_7FFF);
    setv(16'h047E, 4'h1);
    // Falling span on controller I: A3 becomes min, A4 max, bounds swap
    wb(1'b1, `LA_OFS_THR3, 32'h0000_0800);
    span_lo <= 16'h03E8;
    span_hi <= 16'h0000;
    var_bus[0 +: 16] <= 16'h05DC;
    setv(16'h047E, 4'hD);
    // Every serial depth against every request kind
    for (int d = 0; d < 4; d++) begin
      wb(1'b1, `LA_OFS_MODE, 32'h0000_0030 | (d << 8));
      @(posedge clk_i);
      chk("ext_src", d > 1, ext_src);
      for (int k = 0; k < 4; k++) begin
        e[0] = !((d == 0 && (k == 1 || k == 2)) || (d == 1 && k == 2));
        qh.push_back({e[0], ~e[0]});
        panel_host_model_i.request(2'(k));
      end
    end
    wb(1'b1, `LA_OFS_SAFETY, 32'h0000_0555);
    // Restart in each selection with random live state
    for (int c = 0; c < 5; c++) begin
      r = $urandom;
      cur <= r[18:0];
      wb(1'b1, `LA_OFS_MODE, rmode[c]);
      qr.push_back((c == 0) ? r[18:0] :
                   {c != 4, c != 3, c != 3, (c == 2) ? r[15:0] : 16'h0555});
      @(posedge clk_i);
      evt <= 1'b1;
      @(posedge clk_i);
      evt <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk("flash", 1, flash);
      if (c < 4) begin
        qh.push_back(2'b10);
        panel_host_model_i.request(2'h3);
        repeat (2) @(posedge clk_i);
        chk("flash", 0, flash);
      end
    end
    for (int i = 1; i < 7; i++) begin
      panel_host_model_i.press();
      chk("item", i % 6, item);
      if (i == 1) chk("flash", 0, flash);
    end
    wb(1'b1, `LA_OFS_MODE, 32'h0000_0000);
    panel_host_model_i.press();
    chk("item", 1, item);
    panel_host_model_i.press();
    chk("item", 0, item);
    repeat (4) @(posedge clk_i);
    chk("pending", 0, qd.size() + qh.size() + qr.size());
    final_report();
  end
endmodule
`default_nettype wire
